// file: cefa_defines.vh
// constants for the converter event flag aggregator
`ifndef CEFA_DEFINES_VH
`define CEFA_DEFINES_VH
// register indices (byte address is four times the index)
`define CEFA_IDX_SUMMARY 10'h2c0
`define CEFA_IDX_FLAGS 10'h2c1
`define CEFA_IDX_MASK 10'h2c2
`define CEFA_IDX_LANE 10'h2c4
`define CEFA_IDX_CTRL 10'h2c8
`define CEFA_AW 12
// flag bit positions
`define CEFA_BIT_LANE 5
`define CEFA_BIT_PLL 4
`define CEFA_BIT_LINK 3
`define CEFA_BIT_REALIGN 2
`define CEFA_BIT_RSVD 1
`define CEFA_BIT_CLK 0
// reset values
`define CEFA_FLAGS_RST 8'h3f
`define CEFA_MASK_RST 8'h3f
`define CEFA_LANE_RST 8'hff
`define CEFA_CTRL_RST 8'h00
// writable bits of the flag register (bits 5:0)
`define CEFA_FLAG_BITS 8'h3f
// control register fields
`define CEFA_CTRL_LINK_EN 0
`define CEFA_CTRL_PIN_SEL 1
`define CEFA_CTRL_MODE_66 2
`define CEFA_CTRL_SOFT_RST 7
`define CEFA_CTRL_WMASK 8'h07
`endif

// file: cefa_top.v
// event flag, mask and summary registers with avalon-mm slave
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cefa_defines.vh"

// register map, byte address is four times the word index
//   0xb00 summary, bit 0 set while any unmasked flag is up
//   0xb04 sticky flags, write one to clear
//   0xb08 mask, a set bit hides its flag from the summary
//   0xb10 per-lane buffer flags, write one to clear
//   0xb20 control: link enable, pin select, 64b66b mode, soft reset
// bus timing: a request waits one cycle; a write lands on the edge
// where waitrequest is seen low, and read data stand on that edge
// and are held until the next read
// flags other than bit 3 are not gated by the link enable; the host clears them
// after enabling the link, as their earlier state means nothing

// Function
// - summary is one if any unmasked flag
// - summary drives status pin when selected
// - lane buffer error sets bit 5
// - serializer pll unlock sets bit 4
// - 8b10b: enabled link outside user-data sets bit 3
// - 64b66b: startup or realignment sets bit 3
// - sysref realignment sets bit 2
// - divider mismatch a/b vs c/d sets bit 0
// - flags sticky, write one clears
// - reset and soft reset give flags 0x3f
// - only clock flag meaningful while link disabled
// - mask bit hides flag from summary only
// - mask resets to 0x3f
// - per-lane flags set per lane, w1c
// - clearing lane buffer flag clears all lane flags
module cefa_top
(
  input wire clk,
  input wire nrst,
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [7:0] lane_active,
  input wire [7:0] lane_buffer_err,
  input wire serializer_pll_locked,
  input wire user_data_state,
  input wire link_realign_evt,
  input wire sysref_realign_evt,
  input wire [3:0] div_state_ab,
  input wire [3:0] div_state_cd,
  output reg calibration_status_pin,
  output reg serial_link_enable,
  output reg link_mode_66
);

  reg [7:0] flags_r;
  reg [7:0] flags_nxt;
  reg [7:0] mask_r;
  reg [7:0] lane_r;
  reg [7:0] lane_nxt;
  reg [7:0] ctrl_r;
  reg link_en_d_r;
  reg ack_r;
  reg [7:0] rd_nxt;
  wire [9:0] idx;
  wire req;
  wire acc;
  wire wr_flags;
  wire wr_mask;
  wire wr_lane;
  wire wr_ctrl;
  wire soft_rst;
  wire summary;
  wire [7:0] evt;
  wire lane_evt;
  wire link_evt;

  // true when the low byte lane is written at the given index
  function hit_wr;
    input [9:0] a;
    input [9:0] target;
    input w;
    input be0;
    begin
      hit_wr = w & be0 & (a == target);
    end
  endfunction

  assign idx = avs_address[`CEFA_AW-1:2];
  assign req = (avs_read | avs_write) & ~ack_r;
  // writes complete only on the edge where waitrequest is low
  assign acc = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_flags = acc & hit_wr(idx, `CEFA_IDX_FLAGS, avs_write, avs_byteenable[0]);
  assign wr_mask = acc & hit_wr(idx, `CEFA_IDX_MASK, avs_write, avs_byteenable[0]);
  assign wr_lane = acc & hit_wr(idx, `CEFA_IDX_LANE, avs_write, avs_byteenable[0]);
  assign wr_ctrl = acc & hit_wr(idx, `CEFA_IDX_CTRL, avs_write, avs_byteenable[0]);
  assign soft_rst = wr_ctrl & avs_writedata[`CEFA_CTRL_SOFT_RST];

  // summary is a pure function of flags and mask, no delay
  assign summary = |(flags_r & ~mask_r & `CEFA_FLAG_BITS);

  // per-lane errors only count on active lanes
  assign lane_evt = |(lane_buffer_err & lane_active);
  // link flag source depends on the encoding mode
  assign link_evt = ctrl_r[`CEFA_CTRL_MODE_66]
    ? ((ctrl_r[`CEFA_CTRL_LINK_EN] & ~link_en_d_r) | link_realign_evt)
    : (ctrl_r[`CEFA_CTRL_LINK_EN] & ~user_data_state);

  // event vector in flag bit order; only bit 3 depends on the link enable
  assign evt = {2'b00, lane_evt, ~serializer_pll_locked, link_evt, sysref_realign_evt, 1'b0,
                (div_state_ab != div_state_cd)};

  // sticky flags: write one clears, a same-cycle event wins
  always @*
  begin
    flags_nxt = flags_r;
    if (wr_flags)
    begin
      flags_nxt = flags_r & ~(avs_writedata[7:0] & `CEFA_FLAG_BITS);
    end
    flags_nxt = (flags_nxt | evt) & `CEFA_FLAG_BITS;
  end

  // per-lane flags, also wiped by clearing the lane buffer flag
  always @*
  begin
    lane_nxt = lane_r;
    if (wr_lane)
    begin
      lane_nxt = lane_r & ~avs_writedata[7:0];
    end
    if (wr_flags & avs_writedata[`CEFA_BIT_LANE])
    begin
      lane_nxt = 8'h00;
    end
    lane_nxt = lane_nxt | (lane_buffer_err & lane_active);
  end

  // read data mux; unmapped reads return zero
  always @*
  begin
    rd_nxt = 8'h00;
    if (idx == `CEFA_IDX_SUMMARY)
      rd_nxt = {7'h00, summary};
    else if (idx == `CEFA_IDX_FLAGS)
      rd_nxt = flags_r;
    else if (idx == `CEFA_IDX_MASK)
      rd_nxt = mask_r;
    else if (idx == `CEFA_IDX_LANE)
      rd_nxt = lane_r;
    else if (idx == `CEFA_IDX_CTRL)
      rd_nxt = ctrl_r;
  end

  // sticky flag register, soft reset restores defaults
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flags_r <= `CEFA_FLAGS_RST;
    end
    else if (soft_rst)
    begin
      flags_r <= `CEFA_FLAGS_RST;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  // mask register, stored as written
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mask_r <= `CEFA_MASK_RST;
    end
    else if (soft_rst)
    begin
      mask_r <= `CEFA_MASK_RST;
    end
    else if (wr_mask)
    begin
      mask_r <= avs_writedata[7:0];
    end
  end

  // per-lane flag register
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lane_r <= `CEFA_LANE_RST;
    end
    else if (soft_rst)
    begin
      lane_r <= `CEFA_LANE_RST;
    end
    else
    begin
      lane_r <= lane_nxt;
    end
  end

  // control register; soft reset bit is not stored
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_r <= `CEFA_CTRL_RST;
    end
    else if (soft_rst)
    begin
      ctrl_r <= `CEFA_CTRL_RST;
    end
    else if (wr_ctrl)
    begin
      ctrl_r <= avs_writedata[7:0] & `CEFA_CTRL_WMASK;
    end
  end

  // delayed link enable for the 64b66b startup edge
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      link_en_d_r <= 1'b0;
    end
    else if (soft_rst)
    begin
      link_en_d_r <= 1'b0;
    end
    else
    begin
      link_en_d_r <= ctrl_r[`CEFA_CTRL_LINK_EN];
    end
  end

  // bus handshake: one wait cycle, then waitrequest low for one cycle
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      ack_r <= req;
      avs_waitrequest <= ~req;
    end
  end

  // read data captured as the request is taken, held until next read
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (req & avs_read)
    begin
      avs_readdata <= {24'h000000, rd_nxt};
    end
  end

  // status pin follows the summary when selected
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      calibration_status_pin <= 1'b0;
    end
    else
    begin
      calibration_status_pin <= ctrl_r[`CEFA_CTRL_PIN_SEL] & summary;
    end
  end

  // registered copies of control state
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      serial_link_enable <= 1'b0;
      link_mode_66 <= 1'b0;
    end
    else
    begin
      serial_link_enable <= ctrl_r[`CEFA_CTRL_LINK_EN];
      link_mode_66 <= ctrl_r[`CEFA_CTRL_MODE_66];
    end
  end

endmodule // cefa_top
`default_nettype wire

// file: cefa_chk.sv
// port checker for the event flag aggregator
`timescale 1ns/1ns
`default_nettype none
module cefa_chk (
  input wire clk,
  input wire nrst,
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire serial_link_enable,
  input wire link_mode_66,
  input wire calibration_status_pin
);
  // new write to the control word
  wire cw = avs_write && avs_waitrequest && avs_address == 12'hb20;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_ACK: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  AST_ONE: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack too long");
  AST_IDLE: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("ack without request");
  AST_UPPER: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0) else $error("upper bits");
  AST_EN: assert property (cw && avs_byteenable[0] |-> ##3
    serial_link_enable == ($past(avs_writedata[0], 3) && !$past(avs_writedata[7], 3))) else $error("enable");
  AST_MODE: assert property (cw && avs_byteenable[0] |-> ##3
    link_mode_66 == ($past(avs_writedata[2], 3) && !$past(avs_writedata[7], 3))) else $error("mode");
  AST_BE: assert property (cw && !avs_byteenable[0] |-> ##3 $stable(serial_link_enable)) else $error("lane");
  AST_RST: assert property ($rose(nrst) |-> avs_waitrequest && !serial_link_enable &&
    !calibration_status_pin) else $error("reset state");
endmodule // cefa_chk
bind cefa_top cefa_chk i_cefa_chk (.*);
`default_nettype wire

// file: cefa_top_test.sv
// self-checking bench for the event flag aggregator
`timescale 1ns/1ns
`default_nettype none
module cefa_top_test;
  logic clk, nrst, avs_read, avs_write, avs_waitrequest, serializer_pll_locked, user_data_state;
  logic link_realign_evt, sysref_realign_evt, calibration_status_pin, serial_link_enable, link_mode_66;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable, div_state_ab, div_state_cd;
  logic [7:0] lane_active, lane_buffer_err, lbe, fl;
  int n_fail, total_checks, cyc;
  int evs[5] = '{5, 4, 3, 2, 0};
  cefa_top i_cefa_top (.*);
  // clock
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(string n, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task bus(logic [11:0] a, logic w, logic [7:0] d, logic [3:0] b);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= b;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task rdc(string n, logic [11:0] a, logic [7:0] e);
    bus(a, 0, 0, 4'h0);
    chk(n, q, {24'h0, e});
  endtask
  // drive one event source
  task ev(int k, logic v);
    case (k)
      5: lane_buffer_err <= v ? lbe : 8'h0;
      4: serializer_pll_locked <= !v;
      3: user_data_state <= !v;
      2: sysref_realign_evt <= v;
      default: div_state_cd <= v ? ~div_state_ab : div_state_ab;
    endcase
  endtask
  // watchdog
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done;
    end
  end
  // main sequence
  initial
  begin
    void'($urandom(5));
    {nrst, avs_read, avs_write, link_realign_evt, sysref_realign_evt, lane_buffer_err} = 0;
    {avs_address, avs_writedata, avs_byteenable} = 0;
    {serializer_pll_locked, user_data_state, lane_active} = 10'h3ff;
    div_state_ab = 4'($urandom);
    div_state_cd = div_state_ab;
    lbe = 8'h1 << ($urandom % 8);
    repeat (10) @(posedge clk);
    nrst <= 1;
    rdc("summary", 12'hb00, 8'h0);
    rdc("flags", 12'hb04, 8'h3f);
    rdc("mask", 12'hb08, 8'h3f);
    rdc("unmapped", 12'hb0c, 8'h0);
    bus(12'hb20, 1, 8'h03, 4'hf);
    bus(12'hb04, 1, 8'h3f, 4'hf);
    rdc("flags", 12'hb04, 8'h0);
    rdc("lane", 12'hb10, 8'h0);
    $display("reset test done");
    foreach (evs[j])
    begin
      @(posedge clk) ev(evs[j], 1);
      @(posedge clk) ev(evs[j], 0);
      fl = 8'h1 << evs[j];
      rdc("flags", 12'hb04, fl);
      if (evs[j] == 5) rdc("lane", 12'hb10, lbe);
      bus(12'hb04, 1, 8'h0, 4'hf);
      rdc("flags", 12'hb04, fl);
      rdc("summary", 12'hb00, 8'h0);
      bus(12'hb08, 1, ~fl & 8'h3f, 4'hf);
      rdc("summary", 12'hb00, 8'h1);
      chk("pin", calibration_status_pin, 1);
      bus(12'hb04, 1, fl, 4'hf);
      rdc("summary", 12'hb00, 8'h0);
      chk("pin", calibration_status_pin, 0);
      if (evs[j] == 5) rdc("lane", 12'hb10, 8'h0);
      bus(12'hb08, 1, 8'h3f, 4'hf);
      $display("event test %0d done", evs[j]);
    end
    bus(12'hb08, 1, 8'h02, 4'hf);
    bus(12'hb20, 1, 8'h80, 4'h0);
    rdc("flags", 12'hb04, 8'h0);
    bus(12'hb20, 1, 8'h80, 4'hf);
    rdc("flags", 12'hb04, 8'h3f);
    rdc("mask", 12'hb08, 8'h3f);
    chk("enable", serial_link_enable, 0);
    $display("soft reset test done");
    bus(12'hb04, 1, 8'h3f, 4'hf);
    bus(12'hb20, 1, 8'h05, 4'hf);
    rdc("flags", 12'hb04, 8'h08);
    chk("mode", link_mode_66, 1);
    bus(12'hb04, 1, 8'h08, 4'hf);
    @(posedge clk) link_realign_evt <= 1;
    @(posedge clk) link_realign_evt <= 0;
    rdc("flags", 12'hb04, 8'h08);
    $display("link mode test done");
    test_done;
  end
endmodule // cefa_top_test
`default_nettype wire
